// *** logic/external_memory_interface_cfg_pkg.sv ***
// constants and types of the external memory page and mode configuration block
package external_memory_interface_cfg_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_PAGE_SELECT  = 8'hAA;
    localparam logic [7:0] ADDR_MEM_CONFIG   = 8'hAB;
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0] MEM_CONFIG_RESET  = 8'h03;
    localparam logic [7:0] PAGE_WRITE_MASK   = 8'h1F;
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'h0F;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;

    // ==========================================================
    // field positions
    localparam int PAGE_MSB     = 4;
    localparam int PAGE_LOW_MSB = 3;
    localparam int MODE_MSB     = 3;
    localparam int MODE_LSB     = 2;
    localparam int WIDTH_MSB    = 1;

    // ==========================================================
    // interface modes, encoded as the mode field
    typedef enum logic [1:0] {
        MODE_INTERNAL     = 2'h0,
        MODE_SPLIT_NOBANK = 2'h1,
        MODE_SPLIT_BANK   = 2'h2,
        MODE_EXTERNAL     = 2'h3
    } mem_mode_t;

endpackage

// *** logic/ale_link_if.sv ***
// handshake between the move sequencer and the latch-enable pulse generator
`timescale 1ns/1ns
`default_nettype none
interface ale_link_if;
    logic       start;
    logic [1:0] width;
    logic       ale;
    logic       done;

    modport ctl (output start, output width, input ale, input done);
    modport gen (input start, input width, output ale, output done);
endinterface
`default_nettype wire

// *** logic/ale_pulse_gen.sv ***
// latch-enable pulse generator: high phase then low phase of programmed length
`timescale 1ns/1ns
`default_nettype none
module ale_pulse_gen (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // sequencer side
    ale_link_if.gen   link
);
    typedef enum logic [1:0] {ALE_IDLE, ALE_HIGH, ALE_LOW} ale_state_t;

    ale_state_t state;
    ale_state_t next_state;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [1:0] width_q;
    logic [1:0] next_width_q;
    logic       ale;
    logic       next_ale;
    logic       done;
    logic       next_done;

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_width_q = width_q;
        next_ale     = ale;
        next_done    = 1'b0;
        case (state)
            ALE_IDLE: begin
                if (link.start) begin
                    next_state   = ALE_HIGH;
                    next_cnt     = link.width;
                    next_width_q = link.width;
                    next_ale     = 1'b1;
                end
            end
            ALE_HIGH: begin
                if (cnt == 2'h0) begin
                    next_state = ALE_LOW;
                    next_cnt   = width_q;
                    next_ale   = 1'b0;
                end else begin
                    next_cnt = cnt - 2'h1;
                end
            end
            ALE_LOW: begin
                if (cnt == 2'h0) begin
                    next_state = ALE_IDLE;
                    next_done  = 1'b1;
                end else begin
                    next_cnt = cnt - 2'h1;
                end
            end
            default: begin
                next_state = ALE_IDLE;
                next_ale   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state   <= ALE_IDLE;
            cnt     <= 2'h0;
            width_q <= 2'h0;
            ale     <= 1'b0;
            done    <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            width_q <= next_width_q;
            ale     <= next_ale;
            done    <= next_done;
        end
    end

    assign link.ale  = ale;
    assign link.done = done;

    // ==========================================================
    // checks
    ale_min_width_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(ale) && width_q == 2'h0 |-> ##1 !ale ##1 done)
        else $error("latch pulse wrong at width 0");
    ale_max_width_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(ale) && width_q == 2'h3 |-> ale [*4] ##1 !ale [*4] ##1 done)
        else $error("latch pulse wrong at width 3");

endmodule // ale_pulse_gen
`default_nettype wire

// *** logic/ext_mem_page_ctrl.sv ***
// page-select and configuration registers with move routing for the external memory interface
`timescale 1ns/1ns
`default_nettype none
module ext_mem_page_ctrl
    import external_memory_interface_cfg_pkg::*;
#(
    parameter int          ADDR_W       = 16,
    parameter logic [15:0] ONCHIP_BOUND = 16'h1000
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // special function register port
    input  wire logic [7:0]        sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    input  wire logic [7:0]        sfr_wdata,
    output logic      [7:0]        sfr_rdata,
    // move request from the core
    input  wire logic              move_start,
    input  wire logic              move_is_8bit,
    input  wire logic [7:0]        move_ptr,
    input  wire logic [ADDR_W-1:0] move_dptr,
    output logic                   move_busy,
    output logic                   move_done,
    // on-chip memory side
    output logic                   onchip_sel,
    output logic      [ADDR_W-1:0] onchip_addr,
    // off-chip multiplexed bus side
    output logic      [11:0]       ext_addr,
    output logic                   ext_addr_lo_oe,
    output logic                   ext_addr_hi_oe,
    output logic                   ext_ale
);
    typedef enum logic {MV_IDLE, MV_OFFCHIP} move_state_t;

    // ==========================================================
    // registers
    logic [7:0] xram_page_select;
    logic [7:0] ext_mem_config;
    logic [7:0] next_page;
    logic [7:0] next_config;
    logic [7:0] next_rdata;

    always_comb begin
        next_page   = xram_page_select;
        next_config = ext_mem_config;
        next_rdata  = sfr_rdata;
        if (sfr_wr && sfr_addr == ADDR_PAGE_SELECT)
            next_page = sfr_wdata & PAGE_WRITE_MASK;
        if (sfr_wr && sfr_addr == ADDR_MEM_CONFIG)
            next_config = sfr_wdata & CONFIG_WRITE_MASK;
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_PAGE_SELECT: next_rdata = xram_page_select & PAGE_WRITE_MASK;
                ADDR_MEM_CONFIG:  next_rdata = ext_mem_config & CONFIG_WRITE_MASK;
                default:          next_rdata = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            xram_page_select <= PAGE_SELECT_RESET;
            ext_mem_config   <= MEM_CONFIG_RESET;
            sfr_rdata        <= READ_UNMAPPED;
        end else begin
            xram_page_select <= next_page;
            ext_mem_config   <= next_config;
            sfr_rdata        <= next_rdata;
        end
    end

    // ==========================================================
    // routing decisions
    mem_mode_t  cur_mode;
    logic [4:0] page_field;
    assign cur_mode   = mem_mode_t'(ext_mem_config[MODE_MSB:MODE_LSB]);
    assign page_field = xram_page_select[PAGE_MSB:0];

    function automatic logic is_offchip(input mem_mode_t mode, input logic is8,
                                        input logic [4:0] page, input logic [ADDR_W-1:0] dptr);
        case (mode)
            MODE_INTERNAL:     is_offchip = 1'b0;
            MODE_EXTERNAL:     is_offchip = 1'b1;
            default:           is_offchip = is8 ? page[PAGE_MSB]
                                                : (dptr >= ADDR_W'(ONCHIP_BOUND));
        endcase
    endfunction

    // effective address of an 8-bit move: low four page field bits over pointer
    function automatic logic [ADDR_W-1:0] eff_addr(input logic is8, input logic [4:0] page,
                                                   input logic [7:0] ptr, input logic [ADDR_W-1:0] dptr);
        if (is8)
            eff_addr = ADDR_W'({page[PAGE_LOW_MSB:0], ptr});
        else
            eff_addr = dptr;
    endfunction

    logic              req_off;
    logic [ADDR_W-1:0] req_eff;
    assign req_off = is_offchip(cur_mode, move_is_8bit, page_field, move_dptr);
    assign req_eff = eff_addr(move_is_8bit, page_field, move_ptr, move_dptr);

    // ==========================================================
    // move sequencer
    ale_link_if  link ();
    move_state_t state;
    move_state_t next_state;
    logic              next_busy;
    logic              next_done;
    logic              next_sel;
    logic [ADDR_W-1:0] next_onchip_addr;
    logic [11:0]       next_ext_addr;
    logic              next_lo_oe;
    logic              next_hi_oe;
    logic              ale_start;
    logic [1:0]        ale_width;

    // mode and page are sampled only at the start edge, so later writes cannot disturb a move
    always_comb begin
        next_state       = state;
        next_busy        = move_busy;
        next_done        = 1'b0;
        next_sel         = 1'b0;
        next_onchip_addr = onchip_addr;
        next_ext_addr    = ext_addr;
        next_lo_oe       = ext_addr_lo_oe;
        next_hi_oe       = ext_addr_hi_oe;
        ale_start        = 1'b0;
        ale_width        = ext_mem_config[WIDTH_MSB:0];
        case (state)
            MV_IDLE: begin
                if (move_start && !req_off) begin
                    next_sel         = 1'b1;
                    next_done        = 1'b1;
                    // on-chip space wraps past the boundary
                    next_onchip_addr = req_eff % ADDR_W'(ONCHIP_BOUND);
                end else if (move_start) begin
                    next_state = MV_OFFCHIP;
                    next_busy  = 1'b1;
                    ale_start  = 1'b1;
                    next_lo_oe = 1'b1;
                    if (!move_is_8bit) begin
                        next_ext_addr = move_dptr[11:0];
                        next_hi_oe    = 1'b1;
                    end else if (cur_mode == MODE_SPLIT_BANK) begin
                        next_ext_addr = {page_field[PAGE_LOW_MSB:0], move_ptr};
                        next_hi_oe    = 1'b1;
                    end else begin
                        next_ext_addr = {4'h0, move_ptr};
                        next_hi_oe    = 1'b0;
                    end
                end
            end
            MV_OFFCHIP: begin
                if (link.done) begin
                    next_state = MV_IDLE;
                    next_busy  = 1'b0;
                    next_done  = 1'b1;
                    next_lo_oe = 1'b0;
                    next_hi_oe = 1'b0;
                end
            end
            default: next_state = MV_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state          <= MV_IDLE;
            move_busy      <= 1'b0;
            move_done      <= 1'b0;
            onchip_sel     <= 1'b0;
            onchip_addr    <= '0;
            ext_addr       <= 12'h000;
            ext_addr_lo_oe <= 1'b0;
            ext_addr_hi_oe <= 1'b0;
        end else begin
            state          <= next_state;
            move_busy      <= next_busy;
            move_done      <= next_done;
            onchip_sel     <= next_sel;
            onchip_addr    <= next_onchip_addr;
            ext_addr       <= next_ext_addr;
            ext_addr_lo_oe <= next_lo_oe;
            ext_addr_hi_oe <= next_hi_oe;
        end
    end

    assign link.start = ale_start;
    assign link.width = ale_width;
    assign ext_ale    = link.ale;

    ale_pulse_gen u_ale (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .link    (link)
    );

    // ==========================================================
    // checks
    page_read_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        sfr_rd && sfr_addr == ADDR_PAGE_SELECT |=> sfr_rdata[7:5] == 3'h0)
        else $error("page select reserved bits not zero");
    config_read_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        sfr_rd && sfr_addr == ADDR_MEM_CONFIG |=> sfr_rdata[7:4] == 4'h0)
        else $error("config reserved bits not zero");
    page_write_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        sfr_wr && sfr_addr == ADDR_PAGE_SELECT ##1 !(sfr_wr && sfr_addr == ADDR_PAGE_SELECT)
        ##1 sfr_rd && sfr_addr == ADDR_PAGE_SELECT && !sfr_wr
        |=> sfr_rdata == ($past(sfr_wdata, 3) & PAGE_WRITE_MASK))
        else $error("page select readback mismatch");
    split_msb_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        state == MV_IDLE && move_start && move_is_8bit && page_field[PAGE_MSB]
        && (cur_mode == MODE_SPLIT_NOBANK || cur_mode == MODE_SPLIT_BANK) |=> move_busy && ext_addr_lo_oe)
        else $error("split mode page msb did not go off chip");
    internal_only_on_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        state == MV_IDLE && move_start && cur_mode == MODE_INTERNAL |=> onchip_sel && !move_busy)
        else $error("internal mode move left the chip");
    external_all_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        state == MV_IDLE && move_start && cur_mode == MODE_EXTERNAL |=> !onchip_sel && move_busy)
        else $error("external mode move stayed on chip");
    bound_split_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        state == MV_IDLE && move_start && !move_is_8bit
        && (cur_mode == MODE_SPLIT_NOBANK || cur_mode == MODE_SPLIT_BANK)
        && move_dptr < ONCHIP_BOUND |=> onchip_sel && onchip_addr == $past(move_dptr))
        else $error("address below boundary not routed on chip");
    bank_hi_drive_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        state == MV_IDLE && move_start && move_is_8bit && page_field[PAGE_MSB] && cur_mode == MODE_SPLIT_BANK
        |=> ext_addr_hi_oe && ext_addr[11:8] == $past(page_field[PAGE_LOW_MSB:0]) && ext_addr[7:0] == $past(move_ptr))
        else $error("bank select upper address wrong");
    nobank_hi_float_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        state == MV_IDLE && move_start && move_is_8bit
        && (cur_mode == MODE_EXTERNAL || (cur_mode == MODE_SPLIT_NOBANK && page_field[PAGE_MSB]))
        |=> !ext_addr_hi_oe)
        else $error("upper address driven on 8-bit move without bank select");
    hold_in_flight_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        move_busy && !link.done |=> $stable(ext_addr) && $stable(ext_addr_hi_oe))
        else $error("address changed during a move");

endmodule // ext_mem_page_ctrl
`default_nettype wire

// *** tb/ext_latch_model.sv ***
// address latch and upper port lines facing the multiplexed external bus
`timescale 1ns/1ns
`default_nettype none
module ext_latch_model (
    // bus from the block
    input  wire logic [11:0] ext_addr,
    input  wire logic        ext_addr_lo_oe,
    input  wire logic        ext_addr_hi_oe,
    input  wire logic        ext_ale,
    // upper lines held by the port latches when the block lets them go
    input  wire logic [3:0]  port_hi,
    // address as the memory sees it
    output logic      [11:0] mem_addr
);
    logic [7:0] ad_bus;
    logic [7:0] low_q;

    // ==========================================================
    // multiplexed low byte
    // released lines show the inverse so a stale value never passes for a driven one
    assign ad_bus = ext_addr_lo_oe ? ext_addr[7:0] : ~ext_addr[7:0];

    // transparent while latch enable is high, frozen from its falling edge
    always_latch begin
        if (ext_ale) low_q <= ad_bus;
    end

    // ==========================================================
    // upper lines: block or port latches
    assign mem_addr = {ext_addr_hi_oe ? ext_addr[11:8] : port_hi, low_q};
endmodule // ext_latch_model
`default_nettype wire

// *** tb/ext_mem_page_ctrl_test.sv ***
// self-checking testbench of the external memory page and mode configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) check_val(32'(got), 32'(exp))
module ext_mem_page_ctrl_test import external_memory_interface_cfg_pkg::*;;
    // ==========================================================
    // signals
    logic        sys_clk, rstn, sfr_wr, sfr_rd, move_start, move_is_8bit;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, move_ptr, rd_val;
    logic [15:0] move_dptr, onchip_addr, got_onchip;
    logic        move_busy, move_done, onchip_sel, ext_addr_lo_oe, ext_addr_hi_oe, ext_ale;
    logic [11:0] ext_addr, mem_addr, got_ext, got_mem;
    logic        got_sel, got_hi;
    int          ale_cnt, busy_cnt, done_at, errors, check_count, w;

    ext_mem_page_ctrl u_ext_mem_page_ctrl (.sys_clk(sys_clk), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .move_start(move_start), .move_is_8bit(move_is_8bit), .move_ptr(move_ptr),
        .move_dptr(move_dptr), .move_busy(move_busy), .move_done(move_done),
        .onchip_sel(onchip_sel), .onchip_addr(onchip_addr), .ext_addr(ext_addr),
        .ext_addr_lo_oe(ext_addr_lo_oe), .ext_addr_hi_oe(ext_addr_hi_oe), .ext_ale(ext_ale));

    ext_latch_model u_ext_latch_model (.ext_addr(ext_addr), .ext_addr_lo_oe(ext_addr_lo_oe),
        .ext_addr_hi_oe(ext_addr_hi_oe), .ext_ale(ext_ale), .port_hi(4'hA), .mem_addr(mem_addr));

    // ==========================================================
    // tasks
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        `CHECK(sfr_rdata, exp);
    endtask

    // one move; a mid write clears the page register and retries a start while busy
    task automatic do_move(input logic is8, input logic [7:0] ptr, input logic [15:0] dptr,
                           input logic mid_wr);
        @(negedge sys_clk);
        move_is_8bit = is8;
        move_ptr = ptr;
        move_dptr = dptr;
        move_start = 1'b1;
        ale_cnt = 0;
        busy_cnt = 0;
        done_at = 0;
        for (int k = 1; k < 40 && done_at == 0; k++) begin
            @(negedge sys_clk);
            move_start = mid_wr && k == 2;
            sfr_addr = ADDR_PAGE_SELECT;
            sfr_wdata = 8'h00;
            sfr_wr = mid_wr && k == 2;
            if (ext_ale === 1'b1) ale_cnt++;
            if (k == 1) begin
                got_sel = onchip_sel;
                got_onchip = onchip_addr;
            end
            if (move_busy === 1'b1) begin
                busy_cnt++;
                got_ext = ext_addr;
                got_hi = ext_addr_hi_oe;
                got_mem = mem_addr;
            end
            if (move_done === 1'b1) done_at = k;
        end
        `CHECK(done_at != 0, 1'b1);
    endtask

    task automatic setup(input logic [7:0] cfg, input logic [7:0] page);
        sfr_write(ADDR_MEM_CONFIG, cfg);
        sfr_write(ADDR_PAGE_SELECT, page);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        #(8 * 4000);
        errors++;
        wrap_up();
    end

    // ==========================================================
    // tests
    initial begin
        {rstn, sfr_wr, sfr_rd, move_start, move_is_8bit} = 5'h00;
        {sfr_addr, sfr_wdata, move_ptr, move_dptr} = 40'h0;
        repeat (10) @(negedge sys_clk);
        rstn = 1'b1;
        reg_chk(ADDR_PAGE_SELECT, 8'h00);
        reg_chk(ADDR_MEM_CONFIG, 8'h03);
        sfr_write(ADDR_PAGE_SELECT, 8'hFF);
        reg_chk(ADDR_PAGE_SELECT, 8'h1F);
        sfr_write(ADDR_MEM_CONFIG, 8'hFF);
        reg_chk(ADDR_MEM_CONFIG, 8'h0F);
        sfr_write(8'hAC, 8'h55);
        reg_chk(8'hAC, 8'h00);
        end_test("registers");
        // internal only: page low nibble above pointer
        setup(8'h00, 8'h01);
        do_move(1'b1, 8'h10, 16'h0, 1'b0);
        `CHECK({got_sel, got_onchip}, 17'h10110);
        `CHECK(done_at, 1);
        `CHECK(busy_cnt, 0);
        end_test("internal");
        // bank split, every latch-enable width
        for (w = 0; w < 4; w++) begin
            setup(8'h08 | 8'(w), 8'h12);
            do_move(1'b1, 8'h34, 16'h0, 1'b0);
            `CHECK(ale_cnt, w + 1);
            `CHECK(done_at, 2 * w + 4);
            `CHECK(busy_cnt, 2 * w + 3);
            `CHECK({got_sel, got_hi, got_ext}, 14'h1234);
            `CHECK(got_mem, 12'h234);
        end
        end_test("bank split");
        // split without bank: 0x11 off chip, 0x01 on chip
        setup(8'h04, 8'h11);
        do_move(1'b1, 8'h20, 16'h0, 1'b0);
        `CHECK({got_sel, got_hi, got_mem}, 14'h0A20);
        sfr_write(ADDR_PAGE_SELECT, 8'h01);
        do_move(1'b1, 8'h20, 16'h0, 1'b0);
        `CHECK({got_sel, got_onchip}, 17'h10120);
        do_move(1'b0, 8'h0, 16'h0800, 1'b0);
        `CHECK({got_sel, got_onchip}, 17'h10800);
        do_move(1'b0, 8'h0, 16'h1234, 1'b0);
        `CHECK({got_sel, got_hi, got_ext}, 14'h1234);
        end_test("split no bank");
        // external only: page ignored, everything off chip
        setup(8'h0C, 8'h01);
        do_move(1'b1, 8'h20, 16'h0, 1'b0);
        `CHECK({got_sel, got_hi, got_mem}, 14'h0A20);
        do_move(1'b0, 8'h0, 16'h0050, 1'b0);
        `CHECK({got_sel, got_hi, got_ext}, 14'h1050);
        end_test("external");
        // write in mid move leaves the move alone, next move follows it
        setup(8'h0B, 8'h12);
        do_move(1'b1, 8'h34, 16'h0, 1'b1);
        `CHECK({got_hi, got_ext}, 13'h1234);
        `CHECK(done_at, 10);
        reg_chk(ADDR_PAGE_SELECT, 8'h00);
        do_move(1'b1, 8'h34, 16'h0, 1'b0);
        `CHECK({got_sel, got_onchip}, 17'h10034);
        end_test("mid move write");
        wrap_up();
    end
endmodule // ext_mem_page_ctrl_test
`default_nettype wire
